// [core/address_decode_glue.sv]
// Address latch, decoder, wait-state and paging glue for the processor bus
`timescale 1ns/1ns
module address_decode_glue
    import glue_pkg::*;
#(
    parameter logic [3:0] MOTOR_WAIT_STATES = MOTOR_WAITS
)
(
    // Clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   reset_n_i,
    // Processor bus
    input  wire logic [AD_W-1:0]        ad_i,
    input  wire logic [AD_W-1:0]        addr_hi_i,
    input  wire logic                   ale_i,
    input  wire logic                   rd_n_i,
    input  wire logic                   wr_n_i,
    // Memory map control from an output port bit
    input  wire logic                   high_program_memory_enable_n_i,
    // Derived clocks
    output logic                        cpu_clk_o,
    output logic                        motor_clk_o,
    // Latched address and memory addresses
    output logic [AD_W-1:0]             addr_lo_o,
    output logic [PROG_ADDR_W-1:0]      prog_addr_o,
    output logic [RAM_ADDR_W-1:0]       ram_addr_o,
    // Device selects and ready
    output select_t                     sel_o,
    output logic                        ready_o
);
    logic       rst_meta;
    logic       rst_n;
    logic [AD_W-1:0] addr_lo;
    logic       page;
    logic       cpu_clk;
    logic       motor_clk;
    logic [3:0] wait_count;
    select_t    next_sel;
    logic       strobe;
    logic       strobe_d;
    logic [8:0] hi9;
    logic       access_start;
    logic       motor_hit;

    // Reset release through two flops
    // Async assert, sync release; outputs move from the third edge
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Integer divide: the motor clock is only a close approximation
    clock_divider #(.DIVIDE(CPU_DIV)) u_cpu_div
    (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n),
        .clk_div_o (cpu_clk)
    );

    clock_divider #(.DIVIDE(MOTOR_DIV)) u_motor_div
    (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n),
        .clk_div_o (motor_clk)
    );

    // Retimed so every output leaves a flop
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cpu_clk_o   <= 1'b0;
            motor_clk_o <= 1'b0;
        end
        else
        begin
            cpu_clk_o   <= cpu_clk;
            motor_clk_o <= motor_clk;
        end
    end

    // Transparent while ALE high, holds for the rest of the cycle
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            addr_lo <= '0;
        else if (ale_i)
            addr_lo <= ad_i;
    end

    // A7 from the latch; the bus already carries data by now
    assign hi9    = {addr_hi_i, addr_lo[AD_W-1]};
    assign strobe = !rd_n_i || !wr_n_i;

    // Edge detect: one access loads the page or wait count once
    assign access_start = strobe && !strobe_d;
    assign motor_hit    = next_sel.motor != '0;

    function automatic logic is_slot(input logic [8:0] h, input logic [3:0] slot);
        is_slot = (h[8:4] == IO_BASE[8:4]) && (h[3:0] == slot);
    endfunction

    // One-hot decode; priority chain keeps selects exclusive
    always_comb
    begin
        next_sel = '0;
        if (strobe && !ale_i)
        begin
            if (hi9 <= RAM_LAST)
            begin
                if (!high_program_memory_enable_n_i)
                    next_sel.prog = 1'b1;
                else
                    next_sel.ram = 1'b1;
            end
            else if (hi9 >= PROG_BASE)
                next_sel.prog = 1'b1;
            else
            begin
                // Motor chips take either strobe
                for (int i = 0; i < NUM_MOTOR; i++)
                begin
                    if (is_slot(hi9, SLOT_MOTOR0 + 4'(i)))
                        next_sel.motor[i] = 1'b1;
                end
                // Input ports answer reads only
                for (int i = 0; i < NUM_IN_PORT; i++)
                begin
                    if (is_slot(hi9, SLOT_IN0 + 4'(i)) && !rd_n_i)
                        next_sel.in_port[i] = 1'b1;
                end
                // Output ports take writes only
                for (int i = 0; i < NUM_OUT_PORT; i++)
                begin
                    if (is_slot(hi9, SLOT_OUT0 + 4'(i)) && !wr_n_i)
                        next_sel.out_port[i] = 1'b1;
                end
            end
        end
    end

    // Selects lag the strobe by one edge; devices see a settled decode
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            sel_o <= '0;
        else
            sel_o <= next_sel;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            strobe_d <= 1'b0;
        else
            strobe_d <= strobe;
    end

    // Motor accesses stretch the cycle for a fixed count
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            wait_count <= '0;
        else if (access_start && motor_hit)
            wait_count <= MOTOR_WAIT_STATES;
        else if (wait_count != '0)
            wait_count <= wait_count - 4'h1;
    end

    // Rises with the last count so the stretch equals the wait count
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            ready_o <= 1'b1;
        else if (access_start && motor_hit && MOTOR_WAIT_STATES != '0)
            ready_o <= 1'b0;
        else if (wait_count <= 4'h1)
            ready_o <= 1'b1;
    end

    // Page bit written through I/O slot, data bit 0
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            page <= PAGE_RESET;
        else if (!wr_n_i && access_start && is_slot(hi9, SLOT_PAGE))
            page <= ad_i[0];
    end

    // Upper half of code space is paged across the 128 KB device
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prog_addr_o <= '0;
            ram_addr_o  <= '0;
            addr_lo_o   <= '0;
        end
        else
        begin
            addr_lo_o   <= addr_lo;
            prog_addr_o <= {(hi9[8] & page), addr_hi_i, addr_lo};
            ram_addr_o  <= {addr_hi_i[4:0], addr_lo};
        end
    end
endmodule

// [core/clock_divider.sv]
// Divides the crystal clock into one slower square-wave clock
`timescale 1ns/1ns
module clock_divider
    import glue_pkg::*;
#(
    parameter int unsigned DIVIDE = 32
)
(
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    // Divided clock
    output logic      clk_div_o
);
    localparam int unsigned CW   = $clog2(DIVIDE);
    localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);
    localparam logic [CW-1:0] HALF = CW'(DIVIDE / 2);

    logic [CW-1:0] count;

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            count <= '0;
        else if (count == LAST)
            count <= '0;
        else
            count <= count + CW'(1);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            clk_div_o <= 1'b0;
        else
            clk_div_o <= (count >= HALF);
    end
endmodule

// [core/glue_pkg.sv]
// Shared constants and types for the processor address decode glue
package glue_pkg;

    // Clock figures
    localparam int unsigned XTAL_HZ       = 12_000_000;
    localparam int unsigned CPU_CLK_HZ    = 375_000;
    localparam int unsigned MOTOR_CLK_HZ  = 94_000;
    localparam int unsigned CPU_DIV       = XTAL_HZ / CPU_CLK_HZ;
    localparam int unsigned MOTOR_DIV     = XTAL_HZ / MOTOR_CLK_HZ;

    // Bus widths
    localparam int unsigned AD_W          = 8;
    localparam int unsigned HI_ADDR_W     = 9;
    localparam int unsigned PROG_ADDR_W   = 17;
    localparam int unsigned RAM_ADDR_W    = 13;

    // Address map, upper 9 bits of the 16-bit address (A15..A7)
    localparam logic [8:0] RAM_BASE       = 9'h000;
    localparam logic [8:0] RAM_LAST       = 9'h03F;
    localparam logic [8:0] IO_BASE        = 9'h040;
    localparam logic [8:0] PAGE_BASE      = 9'h100;
    localparam logic [8:0] PROG_BASE      = 9'h080;

    // I/O slot field inside the I/O block
    localparam int unsigned NUM_MOTOR     = 2;
    localparam int unsigned NUM_IN_PORT   = 2;
    localparam int unsigned NUM_OUT_PORT  = 2;
    localparam logic [3:0] SLOT_MOTOR0    = 4'h0;
    localparam logic [3:0] SLOT_IN0       = 4'h2;
    localparam logic [3:0] SLOT_OUT0      = 4'h4;
    localparam logic [3:0] SLOT_PAGE      = 4'h6;

    // Wait states for the slow motor devices
    localparam logic [3:0] MOTOR_WAITS    = 4'h3;

    // Reset values
    localparam logic       PAGE_RESET     = 1'b0;

    typedef struct packed {
        logic                    prog;
        logic                    ram;
        logic [NUM_MOTOR-1:0]    motor;
        logic [NUM_IN_PORT-1:0]  in_port;
        logic [NUM_OUT_PORT-1:0] out_port;
    } select_t;

endpackage

// [dv/cpu_bus_model.sv]
// Processor model issuing multiplexed bus cycles
`timescale 1ns/1ns
module cpu_bus_model
    import glue_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        ready_i,
    input  wire select_t     sel_i,
    input  wire logic [29:0] mem_addr_i,
    output logic [7:0]       ad_o,
    output logic [7:0]       addr_hi_o,
    output logic             ale_o,
    output logic             rd_n_o,
    output logic             wr_n_o
);
    initial
        {ad_o, addr_hi_o, ale_o, rd_n_o, wr_n_o} = 19'h00003;
    task automatic access(input logic [15:0] a, input logic wr, input logic [7:0] d,
                          output select_t s, output logic [29:0] m, output int w);
        @(negedge clk_i);
        {addr_hi_o, ad_o, ale_o} = {a, 1'b1};
        @(negedge clk_i);
        {ale_o, rd_n_o, wr_n_o} = {1'b0, wr, !wr};
        // Inverted address driven on reads, never a stale address
        ad_o = wr ? d : ~ad_o;
        @(negedge clk_i);
        w = 0;
        while (!ready_i && w < 20)
        begin
            @(negedge clk_i);
            w++;
        end
        // Answer taken once ready is seen, strobe still held
        s = sel_i;
        m = mem_addr_i;
        @(negedge clk_i);
        {rd_n_o, wr_n_o} = 2'b11;
        ad_o = ~ad_o;
    endtask
endmodule

// [dv/glue_assertions.sv]
// Port checker for the address decode glue
`timescale 1ns/1ns
module glue_assertions
    import glue_pkg::*;
(
    // Clock, reset and processor bus
    input wire logic            sys_clk_i,
    input wire logic            reset_n_i,
    input wire logic [AD_W-1:0] ad_i,
    input wire logic [AD_W-1:0] addr_hi_i,
    input wire logic            ale_i,
    input wire logic            rd_n_i,
    input wire logic            wr_n_i,
    input wire logic            high_program_memory_enable_n_i,
    // Outputs watched
    input wire logic            cpu_clk_o,
    input wire logic            motor_clk_o,
    input wire logic [AD_W-1:0] addr_lo_o,
    input wire select_t         sel_o,
    input wire logic            ready_o
);
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    a_one_select: assert property ($onehot0(sel_o)) else $error("two selects");
    a_idle_none: assert property (rd_n_i && wr_n_i |=> sel_o == '0) else $error("idle select");
    a_cpu_clk: assert property ($rose(cpu_clk_o) |-> ##32 $rose(cpu_clk_o)) else $error("cpu clock");
    a_motor_clk: assert property ($rose(motor_clk_o) |-> ##127 $rose(motor_clk_o)) else $error("motor clock");
    a_addr_latch: assert property (ale_i |-> ##2 addr_lo_o == $past(ad_i, 2)) else $error("latch");
    a_addr_hold: assert property (!ale_i && !$past(ale_i) |=> $stable(addr_lo_o)) else $error("hold");
    a_ram_select: assert property (!rd_n_i && !ale_i && addr_hi_i < 8'h20 && high_program_memory_enable_n_i
        |=> sel_o.ram) else $error("ram");
    a_rom_swap: assert property (!rd_n_i && !ale_i && addr_hi_i < 8'h20 && !high_program_memory_enable_n_i
        |=> sel_o.prog && !sel_o.ram) else $error("swap");
    a_prog_select: assert property (!rd_n_i && !ale_i && addr_hi_i >= 8'h40 |=> sel_o.prog) else $error("prog");
    a_motor_wait: assert property ($rose(|sel_o.motor) |-> !ready_o[*3] ##1 ready_o) else $error("wait");
endmodule
bind address_decode_glue glue_assertions chk (.*);

// [dv/processor_address_decode_glue_tb.sv]
// Self-checking bench for the address decode glue
`timescale 1ns/1ns
module processor_address_decode_glue_tb;
    import glue_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        rom_map_n;
    logic        page;
    logic [31:0] rng;
    int          failures;
    int          tests_run;
    logic [7:0]  ad, addr_hi, addr_lo;
    logic        ale, rd_n, wr_n, ready;
    logic [16:0] prog_addr;
    logic [12:0] ram_addr;
    select_t     sel;
    logic [15:0] corner [10] = '{16'h1FFF, 16'h2000, 16'h2080, 16'h2100, 16'h2180,
                                 16'h2200, 16'h2280, 16'h2380, 16'h3F80, 16'h4000};
    address_decode_glue dut (.sys_clk_i(clk), .reset_n_i(rst_n), .ad_i(ad), .addr_hi_i(addr_hi), .ale_i(ale),
        .rd_n_i(rd_n), .wr_n_i(wr_n), .high_program_memory_enable_n_i(rom_map_n), .cpu_clk_o(), .motor_clk_o(),
        .addr_lo_o(addr_lo), .prog_addr_o(prog_addr), .ram_addr_o(ram_addr), .sel_o(sel), .ready_o(ready));
    cpu_bus_model cpu (.clk_i(clk), .ready_i(ready), .sel_i(sel), .mem_addr_i({prog_addr, ram_addr}),
        .ad_o(ad), .addr_hi_o(addr_hi), .ale_o(ale), .rd_n_o(rd_n), .wr_n_o(wr_n));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic select_t exp_sel(input logic [15:0] a, input logic wr, input logic hn);
        select_t s;
        logic [8:0] h;
        s = '0;
        h = a[15:7];
        if (h <= RAM_LAST && hn)
            s.ram = 1'b1;
        else if (h <= RAM_LAST || h >= PROG_BASE)
            s.prog = 1'b1;
        else if (h[8:4] == IO_BASE[8:4] && h[3:1] == 3'h0)
            s.motor[h[0]] = 1'b1;
        else if (h[8:4] == IO_BASE[8:4] && h[3:1] == 3'h1 && !wr)
            s.in_port[h[0]] = 1'b1;
        else if (h[8:4] == IO_BASE[8:4] && h[3:1] == 3'h2 && wr)
            s.out_port[h[0]] = 1'b1;
        return s;
    endfunction
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1)
        begin
            failures++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask
    task automatic run(input logic [15:0] a, input logic wr, input logic [7:0] d);
        select_t s;
        select_t e;
        logic [29:0] m;
        int w;
        e = exp_sel(a, wr, rom_map_n);
        cpu.access(a, wr, d, s, m, w);
        check(s === e, "select");
        check(w === (|e.motor ? int'(MOTOR_WAITS) : 0), "wait states");
        if (e.ram)
            check(m[12:0] === a[12:0], "ram address");
        if (e.prog)
            check(m[29:13] === {page & a[15], a}, "program address");
        if (wr && a[15:7] == {IO_BASE[8:4], SLOT_PAGE})
            page = d[0];
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        #250000;
        failures++;
        print_verdict();
    end
    initial
    begin
        {rst_n, rom_map_n, page, failures, tests_run, rng} = {3'b010, 64'h0, 32'hE46E};
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        foreach (corner[i])
        begin
            run(corner[i], 1'b0, 8'h00);
            if (!corner[i][14])
                run(corner[i], 1'b1, 8'h5A);
        end
        $display("Corner map test done");
        run(16'h2300, 1'b1, 8'h01);
        run(16'hC123, 1'b0, 8'h00);
        run(16'h2300, 1'b1, 8'h00);
        run(16'hC123, 1'b0, 8'h00);
        rom_map_n = 1'b0;
        run(16'h0456, 1'b0, 8'h00);
        $display("Paging test done");
        repeat (60)
        begin
            rng = xs(rng);
            rom_map_n = rng[17] | rng[18];
            run(rng[15:0] & (rng[17] ? 16'h3FFF : 16'hFFFF), rng[17], rng[31:24]);
        end
        $display("Random test done");
        print_verdict();
    end
endmodule
